// *** hw/adcrc_top.sv ***
// converter register control: wishbone slave, start detect, result format
//
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module adcrc_top (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic low_voltage_reset_en_i,
   input wire logic [9:0] conv_data_i,
   output logic conv_clk_en_o,
   output logic conv_power_o,
   output adcrc_pkg::adcrc_analog_t analog_sel_o,
   output logic [3:0] analog_pin_mask_o,
   output logic irq_o
);
   logic [7:0] ctrl0_q;
   logic [7:0] ctrl1_q;
   logic bg_en_q;
   logic start_prev_q;
   logic busy_q;
   logic [9:0] result_q;
   logic [6:0] div_cnt_q;
   logic [3:0] conv_cnt_q;
   logic irq_stat_q;
   logic irq_en_q;
   adcrc_pkg::adcrc_state_t state_q;
   logic wr_stb;
   logic ack_q;
   logic start_fall;
   logic tick;
   logic conv_done;
   logic clr_irq;
   logic [7:0] res_high;
   logic [7:0] res_low;

   function automatic logic [6:0] div_mask(input logic [2:0] code);
      div_mask = 7'((8'h01 << code) - 8'h01);
   endfunction

   // writes land on the edge where the master sees ack, not one earlier
   assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
   assign start_fall = start_prev_q & ~ctrl0_q[adcrc_pkg::CTRL0_START];
   assign tick = (div_cnt_q & div_mask(ctrl1_q[2:0])) == 7'h00;
   assign conv_done = (state_q == adcrc_pkg::ADCRC_CONV) & tick &
                      (conv_cnt_q == adcrc_pkg::CONV_CYCLES);
   assign clr_irq = wr_stb & (wb_adr_i == adcrc_pkg::ADDR_IRQ_CLR) &
                    wb_dat_i[0];

   always_comb begin
      if (ctrl0_q[adcrc_pkg::CTRL0_JUST]) begin
         res_high = {6'h00, result_q[9:8]};
         res_low = result_q[7:0];
      end else begin
         res_high = result_q[9:2];
         res_low = {result_q[1:0], 6'h00};
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_q <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
         wb_dat_o <= 32'h0000_0000;
         if (wb_cyc_i & wb_stb_i & ~ack_q & ~wb_we_i) begin
            unique case (wb_adr_i)
               {1'b0, adcrc_pkg::ADDR_RES_HIGH}: wb_dat_o[7:0] <= res_high;
               {1'b0, adcrc_pkg::ADDR_RES_LOW}: wb_dat_o[7:0] <= res_low;
               {1'b0, adcrc_pkg::ADDR_CTRL0}: begin
                  wb_dat_o[7:0] <= ctrl0_q;
                  wb_dat_o[adcrc_pkg::CTRL0_BUSY] <= busy_q;
               end
               {1'b0, adcrc_pkg::ADDR_CTRL1}: wb_dat_o[7:0] <= ctrl1_q;
               adcrc_pkg::ADDR_BANDGAP:
                  wb_dat_o[adcrc_pkg::BANDGAP_EN] <= bg_en_q;
               adcrc_pkg::ADDR_IRQ_STAT: wb_dat_o[0] <= irq_stat_q;
               adcrc_pkg::ADDR_IRQ_EN: wb_dat_o[0] <= irq_en_q;
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign wb_ack_o = ack_q;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl0_q <= adcrc_pkg::CTRL0_RESET;
         ctrl1_q <= adcrc_pkg::CTRL1_RESET;
         bg_en_q <= 1'b0;
         irq_en_q <= 1'b0;
      end else if (wr_stb) begin
         if (wb_adr_i == {1'b0, adcrc_pkg::ADDR_CTRL0})
            ctrl0_q <= wb_dat_i[7:0] & 8'hbf;
         if (wb_adr_i == {1'b0, adcrc_pkg::ADDR_CTRL1})
            ctrl1_q <= wb_dat_i[7:0];
         if (wb_adr_i == adcrc_pkg::ADDR_BANDGAP)
            bg_en_q <= wb_dat_i[adcrc_pkg::BANDGAP_EN];
         if (wb_adr_i == adcrc_pkg::ADDR_IRQ_EN)
            irq_en_q <= wb_dat_i[0];
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start_prev_q <= 1'b0;
      end else begin
         start_prev_q <= ctrl0_q[adcrc_pkg::CTRL0_START];
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_cnt_q <= adcrc_pkg::DIV_RESET;
         conv_clk_en_o <= 1'b0;
      end else begin
         div_cnt_q <= div_cnt_q + 7'h01;
         conv_clk_en_o <= tick & (state_q == adcrc_pkg::ADCRC_CONV);
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= adcrc_pkg::ADCRC_IDLE;
         busy_q <= 1'b0;
         conv_cnt_q <= 4'h0;
      end else if (!ctrl0_q[adcrc_pkg::CTRL0_EN]) begin
         // disable aborts; result is left as it was
         state_q <= adcrc_pkg::ADCRC_IDLE;
         busy_q <= 1'b0;
         conv_cnt_q <= 4'h0;
      end else begin
         unique case (state_q)
            adcrc_pkg::ADCRC_IDLE: if (start_fall) begin
               state_q <= adcrc_pkg::ADCRC_CONV;
               busy_q <= 1'b1;
               conv_cnt_q <= 4'h0;
            end
            adcrc_pkg::ADCRC_CONV: begin
               if (tick)
                  conv_cnt_q <= conv_cnt_q + 4'h1;
               if (conv_done) begin
                  state_q <= adcrc_pkg::ADCRC_DONE;
                  busy_q <= 1'b0;
               end
            end
            adcrc_pkg::ADCRC_DONE: state_q <= adcrc_pkg::ADCRC_IDLE;
            default: state_q <= adcrc_pkg::ADCRC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         result_q <= adcrc_pkg::RESULT_RESET;
      end else if (conv_done & ctrl0_q[adcrc_pkg::CTRL0_EN]) begin
         result_q <= conv_data_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_stat_q <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         irq_stat_q <= (conv_done & ctrl0_q[adcrc_pkg::CTRL0_EN]) |
                       (irq_stat_q & ~clr_irq);
         irq_o <= irq_stat_q & irq_en_q;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         conv_power_o <= 1'b0;
         analog_sel_o <= '0;
         analog_pin_mask_o <= 4'h0;
      end else begin
         conv_power_o <= ctrl0_q[adcrc_pkg::CTRL0_EN];
         analog_sel_o.ext_channel_select <= ctrl0_q[3:0];
         analog_sel_o.input_source_select <= ctrl1_q[7:5];
         analog_sel_o.reference_select <= ctrl1_q[4:3];
         analog_sel_o.bandgap_on <= bg_en_q | low_voltage_reset_en_i;
         analog_pin_mask_o <= 4'h0;
         if (ctrl0_q[3:2] == 2'b00 &&
             (ctrl1_q[7:5] == 3'b000 || ctrl1_q[7:5] > 3'b100))
            analog_pin_mask_o <= 4'(4'h1 << ctrl0_q[1:0]);
      end
   end

   property p_busy_set;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (start_fall & ctrl0_q[5] & (state_q == adcrc_pkg::ADCRC_IDLE))
         |=> busy_q;
   endproperty
   a_busy_set: assert property (p_busy_set)
      else $error("busy not set after start");

   property p_busy_clr;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      conv_done |=> !busy_q;
   endproperty
   a_busy_clr: assert property (p_busy_clr)
      else $error("busy not cleared at end");

   property p_disable;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !ctrl0_q[5] |=> !busy_q;
   endproperty
   a_disable: assert property (p_disable)
      else $error("busy while disabled");

   property p_hold;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !ctrl0_q[5] |=> $stable(result_q);
   endproperty
   a_hold: assert property (p_hold)
      else $error("result changed while disabled");

   property p_just;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      ctrl0_q[4] |-> res_high[7:2] == 6'h00;
   endproperty
   a_just: assert property (p_just)
      else $error("unused high bits not zero");

   property p_irq;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (conv_done & ctrl0_q[5]) |=> irq_stat_q;
   endproperty
   a_irq: assert property (p_irq)
      else $error("request flag not set");

   property p_bg;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      low_voltage_reset_en_i |=> analog_sel_o.bandgap_on;
   endproperty
   a_bg: assert property (p_bg)
      else $error("bandgap off with reset function");

   property p_tick;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ctrl1_q[2:0] == 3'b001 && $stable(ctrl1_q)) |-> tick != $past(tick);
   endproperty
   a_tick: assert property (p_tick)
      else $error("divide by two wrong");

   property p_start_only;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(busy_q) |-> $past(start_fall);
   endproperty
   a_start_only: assert property (p_start_only)
      else $error("busy rose without start sequence");

   property p_busy_ro;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !ctrl0_q[adcrc_pkg::CTRL0_BUSY];
   endproperty
   a_busy_ro: assert property (p_busy_ro)
      else $error("busy position took a written value");

   property p_left;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !ctrl0_q[4] |-> {res_high, res_low} == {result_q, 6'h00};
   endproperty
   a_left: assert property (p_left)
      else $error("left format wrong");

   property p_right;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      ctrl0_q[4] |-> {res_high, res_low} == {6'h00, result_q};
   endproperty
   a_right: assert property (p_right)
      else $error("right format wrong");

   property p_pad;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !ctrl0_q[4] |-> res_low[5:0] == 6'h00;
   endproperty
   a_pad: assert property (p_pad)
      else $error("unused low bits not zero");

   property p_power;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      conv_power_o == $past(ctrl0_q[adcrc_pkg::CTRL0_EN]);
   endproperty
   a_power: assert property (p_power)
      else $error("converter power does not follow enable");

   property p_load;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (conv_done & ctrl0_q[5]) |=> result_q == $past(conv_data_i);
   endproperty
   a_load: assert property (p_load)
      else $error("result not loaded at completion");

   property p_len;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state_q == adcrc_pkg::ADCRC_CONV) |->
         conv_cnt_q <= adcrc_pkg::CONV_CYCLES;
   endproperty
   a_len: assert property (p_len)
      else $error("conversion ran past its length");

   property p_clk_en;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      conv_clk_en_o |-> $past(state_q) == adcrc_pkg::ADCRC_CONV;
   endproperty
   a_clk_en: assert property (p_clk_en)
      else $error("converter clock outside conversion");

   property p_pin;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (analog_pin_mask_o != 4'h0) |-> $onehot(analog_pin_mask_o) &&
         analog_sel_o.ext_channel_select[3:2] == 2'b00;
   endproperty
   a_pin: assert property (p_pin)
      else $error("pin claimed for a floating channel");

   property p_quarter;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (analog_sel_o.input_source_select != 3'b000 &&
       analog_sel_o.input_source_select <= 3'b100) |->
         analog_pin_mask_o == 4'h0;
   endproperty
   a_quarter: assert property (p_quarter)
      else $error("pin claimed for an internal source");

   property p_bg_off;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!bg_en_q && !low_voltage_reset_en_i) |=>
         !analog_sel_o.bandgap_on;
   endproperty
   a_bg_off: assert property (p_bg_off)
      else $error("bandgap on with no request");

   property p_irq_out;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      irq_o == $past(irq_stat_q & irq_en_q);
   endproperty
   a_irq_out: assert property (p_irq_out)
      else $error("interrupt output does not follow status");

   c_conv: cover property (@(posedge clk_sys_i) conv_done);
   c_irq: cover property (@(posedge clk_sys_i) irq_o);
   c_abort: cover property (@(posedge clk_sys_i) busy_q ##1 !ctrl0_q[5]);
   c_right: cover property (@(posedge clk_sys_i) conv_done & ctrl0_q[4]);
   c_quarter: cover property (@(posedge clk_sys_i)
      analog_sel_o.input_source_select == 3'b100);
endmodule // adcrc_top

// *** hw/adcrc_pkg.sv ***
// package: register map, fields and constants of the converter control block
package adcrc_pkg;
   localparam logic [3:0] ADDR_RES_HIGH = 4'h0;
   localparam logic [3:0] ADDR_RES_LOW = 4'h4;
   localparam logic [3:0] ADDR_CTRL0 = 4'h8;
   localparam logic [3:0] ADDR_CTRL1 = 4'hc;
   localparam logic [4:0] ADDR_BANDGAP = 5'h10;
   localparam logic [4:0] ADDR_IRQ_STAT = 5'h14;
   localparam logic [4:0] ADDR_IRQ_EN = 5'h18;
   localparam logic [4:0] ADDR_IRQ_CLR = 5'h1c;
   localparam int CTRL0_START = 7;
   localparam int CTRL0_BUSY = 6;
   localparam int CTRL0_EN = 5;
   localparam int CTRL0_JUST = 4;
   localparam int BANDGAP_EN = 3;
   localparam logic [7:0] CTRL0_RESET = 8'h00;
   localparam logic [7:0] CTRL1_RESET = 8'h00;
   localparam logic [9:0] RESULT_RESET = 10'h000;
   // converter clock count at which a conversion ends; a conversion takes 13 converter clocks
   localparam logic [3:0] CONV_CYCLES = 4'hc;
   localparam logic [6:0] DIV_RESET = 7'h00;
   typedef enum logic [2:0] {
      ADCRC_IDLE = 3'b001,
      ADCRC_CONV = 3'b010,
      ADCRC_DONE = 3'b100
   } adcrc_state_t;
   typedef struct packed {
      logic [3:0] ext_channel_select;
      logic [2:0] input_source_select;
      logic [1:0] reference_select;
      logic bandgap_on;
   } adcrc_analog_t;
endpackage

// *** tb/adcrc_conv_model.sv ***
// converter core stand-in: returns a sample while powered
`timescale 1ns/1ps
module adcrc_conv_model (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic conv_power_i,
   input wire logic [9:0] sample_i,
   output logic [9:0] conv_data_o
);
   logic [9:0] last_q;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         last_q <= 10'h000;
      end else if (conv_power_i) begin
         last_q <= sample_i;
      end
   end
   // unpowered core
   // a switched-off core gives no valid code, so show a changed one
   assign conv_data_o = conv_power_i ? sample_i : ~last_q;
endmodule // adcrc_conv_model

// *** tb/test_adcrc_top.sv ***
// self-checking bench for the converter register control block
`timescale 1ns/1ps
module test_adcrc_top;
   localparam logic [4:0] A_HI = {1'b0, adcrc_pkg::ADDR_RES_HIGH};
   localparam logic [4:0] A_LO = {1'b0, adcrc_pkg::ADDR_RES_LOW};
   localparam logic [4:0] A_C0 = {1'b0, adcrc_pkg::ADDR_CTRL0};
   localparam logic [4:0] A_C1 = {1'b0, adcrc_pkg::ADDR_CTRL1};
   logic clk, rst_n, cyc, stb, we, ack, low_voltage_reset, cken, pwr, irq;
   logic [4:0] adr;
   logic [31:0] wdat, rdat, rd, gap_exp;
   logic [9:0] cdat, sample;
   logic [3:0] mask;
   logic [15:0] last_exp;
   logic [15:0] exp_q[$];
   adcrc_pkg::adcrc_analog_t asel;
   int n_errors = 0;
   int samples_checked = 0;
   int cyc_cnt = 0;
   int last_pulse = -1;

   adcrc_top u_dut (.clk_sys_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .low_voltage_reset_en_i(low_voltage_reset), .conv_data_i(cdat),
      .conv_clk_en_o(cken), .conv_power_o(pwr), .analog_sel_o(asel),
      .analog_pin_mask_o(mask), .irq_o(irq));
   adcrc_conv_model u_core (.clk_sys_i(clk), .rst_n_i(rst_n),
      .conv_power_i(pwr), .sample_i(sample), .conv_data_o(cdat));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
      chk(got, exp);
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // one classic cycle; request held until ack is sampled
   task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50)
         n_errors++;
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rdx(input logic [4:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(rd, {24'h000000, e});
   endtask

   task automatic settle;
      repeat (3) @(posedge clk);
   endtask

   function automatic logic [15:0] fmt(input logic [9:0] d, input logic j);
      return j ? {6'h00, d} : {d, 6'h00};
   endfunction

   always @(posedge clk) begin
      cyc_cnt++;
      if (cken === 1'b1) begin
         if (last_pulse >= 0)
            chk_out(cyc_cnt - last_pulse, gap_exp);
         last_pulse = cyc_cnt;
      end
   end

   task automatic conv(input logic [2:0] code, input logic j, input logic en);
      logic [7:0] c0;
      int n;
      c0 = {2'b00, en, j, 4'h0};
      sample <= 10'($urandom);
      gap_exp = 32'd1 << code;
      wb(1'b1, A_C1, {5'h00, code});
      wb(1'b1, adcrc_pkg::ADDR_IRQ_EN, {7'h00, code[0]});
      wb(1'b1, A_C0, c0);
      last_pulse = -1;
      wb(1'b1, A_C0, c0 | 8'h80);
      wb(1'b1, A_C0, c0);
      if (en)
         exp_q.push_back(fmt(sample, j));
      rdx(A_C0, c0 | {1'b0, en, 6'h00});
      n = 0;
      while (rd[6] === 1'b1 && n < 800) begin
         wb(1'b0, A_C0, 8'h00);
         n++;
      end
      chk_out({31'h0, rd[6]}, 32'h0);
      if (exp_q.size() > 0)
         last_exp = exp_q.pop_front();
      rdx(A_HI, last_exp[15:8]);
      rdx(A_LO, last_exp[7:0]);
      rdx(adcrc_pkg::ADDR_IRQ_STAT, {7'h00, en});
      settle;
      chk_out({31'h0, irq}, {31'h0, en & code[0]});
      chk_out({31'h0, pwr}, {31'h0, en});
      wb(1'b1, adcrc_pkg::ADDR_IRQ_CLR, 8'h01);
      settle;
      chk_out({31'h0, irq}, 32'h0);
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      n_errors++;
      close_out;
   end

   initial begin
      logic [2:0] s;
      logic [3:0] c, m;
      logic [1:0] r;
      rst_n = 1'b0;
      {cyc, stb, we, low_voltage_reset} = 4'h0;
      adr = 5'h00;
      wdat = 32'h0;
      sample = 10'h000;
      last_exp = 16'h0000;
      gap_exp = 32'h1;
      void'($urandom(30666));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rdx(A_C0, adcrc_pkg::CTRL0_RESET);
      rdx(A_C1, adcrc_pkg::CTRL1_RESET);
      rdx(5'h1e, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 8; i++)
         conv(i[2:0], i[1], 1'b1);
      conv(3'h2, 1'b1, 1'b0);
      $display("test conversion done");
      for (int i = 0; i < 16; i++) begin
         s = (i < 8) ? i[2:0] : 3'($urandom);
         c = 4'($urandom);
         if (s == 3'h4)
            c = c | 4'h4;
         r = 2'($urandom);
         wb(1'b1, A_C1, {s, r, 3'h0});
         wb(1'b1, A_C0, {4'h6, c});
         settle;
         m = ((s == 3'h0 || s > 3'h4) && c < 4'h4) ? 4'h1 << c : 4'h0;
         chk_out(32'(asel), {22'h0, c, s, r, 1'b0});
         chk_out({28'h0, mask}, {28'h0, m});
      end
      $display("test routing done");
      for (int i = 0; i < 4; i++) begin
         low_voltage_reset <= i[1];
         wb(1'b1, adcrc_pkg::ADDR_BANDGAP, i[0] ? 8'hff : 8'hf7);
         rdx(adcrc_pkg::ADDR_BANDGAP, {4'h0, i[0], 3'h0});
         settle;
         chk_out({31'h0, asel.bandgap_on}, {31'h0, i[0] | i[1]});
      end
      $display("test bandgap done");
      close_out;
   end
endmodule // test_adcrc_top
